// ### design/mefu_pkg.sv
// constants and types shared by the masked event flag unit
package mefu_pkg;

  localparam int MEFU_BUS_W = 32;
  localparam int MEFU_REG_W = 28;
  localparam int MEFU_IDX_W = 6;

  // register indices, byte address is four times the index
  localparam logic [5:0] MEFU_IDX_ERR_MASK = 6'h0B;
  localparam logic [5:0] MEFU_IDX_IRQ_MASK = 6'h0C;
  localparam logic [5:0] MEFU_IDX_STATUS = 6'h10;
  localparam logic [5:0] MEFU_IDX_STAT_EN = 6'h11;
  localparam logic [5:0] MEFU_IDX_TIMER = 6'h12;

  localparam int MEFU_HIT_FIFOS = 8;
  localparam int MEFU_IF_FIFOS = 2;

  // mask fields inside the two mask registers
  localparam int MEFU_ERR_LSB = 16;
  localparam int MEFU_ERR_W = 11;
  localparam int MEFU_IRQ_LSB = 13;
  localparam int MEFU_IRQ_W = 13;
  // event positions inside the interrupt source vector
  localparam int MEFU_SRC_IF_LSB = 8;
  localparam int MEFU_SRC_PLL = 10;
  localparam int MEFU_SRC_EMPTY = 11;
  localparam int MEFU_SRC_TIMER = 12;

  // timer control register fields
  localparam int MEFU_TMR_PER_LSB = 0;
  localparam int MEFU_TMR_PER_W = 13;
  localparam int MEFU_TMR_START_BIT = 16;
  localparam int MEFU_TMR_RUN_BIT = 17;
  localparam int MEFU_TMR_DONE_BIT = 18;

  localparam logic [27:0] MEFU_REG_RST = 28'h000_0000;
  localparam logic [31:0] MEFU_RD_ZERO = 32'h0000_0000;

  // timer tick is one reference period rounded up to whole clock cycles
  localparam int MEFU_TREF_NS = 25;
  localparam int MEFU_CLK_NS = 10;
  localparam int MEFU_TICK_CYC = (MEFU_TREF_NS + MEFU_CLK_NS - 1) / MEFU_CLK_NS;

  typedef enum logic [2:0] {
    MEFU_TMR_IDLE = 3'b001,
    MEFU_TMR_RUN = 3'b010,
    MEFU_TMR_DONE = 3'b100
  } mefu_tmr_state_t;

endpackage

// ### design/mefu_mask_or.sv
// masked or of an event vector
`timescale 1ns/1ps
module mefu_mask_or #(
  parameter int W = 13
) (
  input wire logic [W-1:0] events_in,
  input wire logic [W-1:0] mask_in,
  output logic any_out
);

  // a zero mask bit removes its event completely
  assign any_out = |(events_in & mask_in);

endmodule

// ### design/mefu_interval_timer.sv
// interval timer counting whole reference periods
`timescale 1ns/1ps
module mefu_interval_timer #(
  parameter int PERIOD_W = 13,
  parameter int TICK_CYC = mefu_pkg::MEFU_TICK_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [PERIOD_W-1:0] period_in,
  output logic running_out,
  output logic expired_out
);

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

  mefu_pkg::mefu_tmr_state_t state_ff, nxt_state;
  logic [TW-1:0] tick_ff, nxt_tick;
  logic [PERIOD_W-1:0] per_ff, nxt_per;
  logic [PERIOD_W-1:0] period_ff, nxt_period;

  wire tick_end = (tick_ff == TICK_LAST);
  wire per_end = (per_ff == period_ff - PERIOD_W'(1));

  always_comb begin
    nxt_state = state_ff;
    nxt_tick = tick_ff;
    nxt_per = per_ff;
    nxt_period = period_ff;
    // a new start restarts the interval from any state
    if (start_in) begin
      nxt_period = period_in;
      nxt_tick = '0;
      nxt_per = '0;
      nxt_state = (period_in == '0) ? mefu_pkg::MEFU_TMR_DONE : mefu_pkg::MEFU_TMR_RUN;
    end else begin
      unique case (state_ff)
        mefu_pkg::MEFU_TMR_IDLE: begin
        end
        mefu_pkg::MEFU_TMR_RUN: begin
          nxt_tick = tick_end ? '0 : tick_ff + TW'(1);
          if (tick_end) begin
            nxt_per = per_ff + PERIOD_W'(1);
            if (per_end) begin
              nxt_state = mefu_pkg::MEFU_TMR_DONE;
            end
          end
        end
        mefu_pkg::MEFU_TMR_DONE: begin
        end
        default: nxt_state = mefu_pkg::MEFU_TMR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= mefu_pkg::MEFU_TMR_IDLE;
      tick_ff <= '0;
      per_ff <= '0;
      period_ff <= '0;
    end else if (ce_in) begin
      state_ff <= nxt_state;
      tick_ff <= nxt_tick;
      per_ff <= nxt_per;
      period_ff <= nxt_period;
    end
  end

  assign running_out = (state_ff == mefu_pkg::MEFU_TMR_RUN);
  // expiry stays as a level until the next start
  assign expired_out = (state_ff == mefu_pkg::MEFU_TMR_DONE);

endmodule

// ### design/mefu_top.sv
// masked event flag unit with ahb-lite register slave
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module mefu_top #(
  parameter int HIT_FIFOS = mefu_pkg::MEFU_HIT_FIFOS,
  parameter int IF_FIFOS = mefu_pkg::MEFU_IF_FIFOS
) (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic [HIT_FIFOS-1:0] HIT_FULL_IN,
  input wire logic [IF_FIFOS-1:0] IF_FULL_IN,
  input wire logic PLL_UNLOCK_IN,
  input wire logic HIT_EMPTY_IN,
  output logic IRQ_OUTPUT_OUT,
  output logic FAULT_OUTPUT_OUT,
  output logic STATUS_IRQ_OUT
);

  localparam int RW = mefu_pkg::MEFU_REG_W;
  localparam int IW = mefu_pkg::MEFU_IRQ_W;
  localparam int EW = mefu_pkg::MEFU_ERR_W;
  localparam int PW = mefu_pkg::MEFU_TMR_PER_W;

  function automatic logic reg_sel(input logic [31:0] addr, input logic [5:0] idx);
    reg_sel = (addr[1:0] == 2'b00) && (addr[31:8] == '0) && (addr[7:2] == idx);
  endfunction

  logic [RW-1:0] err_mask_ff, nxt_err_mask;
  logic [RW-1:0] irq_mask_ff, nxt_irq_mask;
  logic [IW-1:0] stat_ff, nxt_stat;
  logic [IW-1:0] stat_en_ff, nxt_stat_en;
  logic [PW-1:0] tmr_per_ff, nxt_tmr_per;
  logic wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic irq_flag_ff;
  logic fault_flag_ff;
  logic stat_irq_ff;

  logic tmr_running;
  logic tmr_expired;
  logic irq_any;
  logic fault_any;

  // event vectors in mask field order
  wire [IW-1:0] irq_src = {tmr_expired, HIT_EMPTY_IN, PLL_UNLOCK_IN, IF_FULL_IN, HIT_FULL_IN};
  wire [EW-1:0] err_src = {PLL_UNLOCK_IN, IF_FULL_IN, HIT_FULL_IN};
  wire [IW-1:0] irq_mask_fld = irq_mask_ff[mefu_pkg::MEFU_IRQ_LSB +: IW];
  wire [EW-1:0] err_mask_fld = err_mask_ff[mefu_pkg::MEFU_ERR_LSB +: EW];

  // bus decode
  wire addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  wire rd_req = addr_ok && !HWRITE_IN;
  wire wr_req = addr_ok && HWRITE_IN;
  wire [RW-1:0] wdat = HWDATA_IN[RW-1:0];
  wire wr_err = wr_pend_ff && reg_sel(wr_addr_ff, mefu_pkg::MEFU_IDX_ERR_MASK);
  wire wr_irq = wr_pend_ff && reg_sel(wr_addr_ff, mefu_pkg::MEFU_IDX_IRQ_MASK);
  wire wr_stat = wr_pend_ff && reg_sel(wr_addr_ff, mefu_pkg::MEFU_IDX_STATUS);
  wire wr_sten = wr_pend_ff && reg_sel(wr_addr_ff, mefu_pkg::MEFU_IDX_STAT_EN);
  wire wr_tmr = wr_pend_ff && reg_sel(wr_addr_ff, mefu_pkg::MEFU_IDX_TIMER);
  wire tmr_start = wr_tmr && HWDATA_IN[mefu_pkg::MEFU_TMR_START_BIT];

  // next register values; reads use them so a write just before is seen
  assign nxt_err_mask = wr_err ? wdat : err_mask_ff;
  assign nxt_irq_mask = wr_irq ? wdat : irq_mask_ff;
  assign nxt_stat_en = wr_sten ? wdat[IW-1:0] : stat_en_ff;
  assign nxt_tmr_per = wr_tmr ? wdat[mefu_pkg::MEFU_TMR_PER_LSB +: PW] : tmr_per_ff;
  // an event in the clearing cycle wins over the write of one
  assign nxt_stat = (stat_ff & ~(wr_stat ? wdat[IW-1:0] : '0)) | irq_src;

  wire [31:0] rd_err = {4'h0, nxt_err_mask};
  wire [31:0] rd_irq = {4'h0, nxt_irq_mask};
  wire [31:0] rd_stat = {{(32-IW){1'b0}}, nxt_stat};
  wire [31:0] rd_sten = {{(32-IW){1'b0}}, nxt_stat_en};
  wire [31:0] rd_tmr = {13'h0000, tmr_expired, tmr_running, 4'h0, nxt_tmr_per};
  wire [31:0] rd_val = reg_sel(HADDR_IN, mefu_pkg::MEFU_IDX_ERR_MASK) ? rd_err :
                       reg_sel(HADDR_IN, mefu_pkg::MEFU_IDX_IRQ_MASK) ? rd_irq :
                       reg_sel(HADDR_IN, mefu_pkg::MEFU_IDX_STATUS) ? rd_stat :
                       reg_sel(HADDR_IN, mefu_pkg::MEFU_IDX_STAT_EN) ? rd_sten :
                       reg_sel(HADDR_IN, mefu_pkg::MEFU_IDX_TIMER) ? rd_tmr :
                       mefu_pkg::MEFU_RD_ZERO;

  mefu_interval_timer #(
    .PERIOD_W(PW),
    .TICK_CYC(mefu_pkg::MEFU_TICK_CYC)
  ) u_timer (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CE_IN),
    .start_in(tmr_start),
    .period_in(wdat[mefu_pkg::MEFU_TMR_PER_LSB +: PW]),
    .running_out(tmr_running),
    .expired_out(tmr_expired)
  );

  mefu_mask_or #(
    .W(IW)
  ) u_irq_or (
    .events_in(irq_src),
    .mask_in(irq_mask_fld),
    .any_out(irq_any)
  );

  mefu_mask_or #(
    .W(EW)
  ) u_fault_or (
    .events_in(err_src),
    .mask_in(err_mask_fld),
    .any_out(fault_any)
  );

  // bus slave: zero wait states, always okay
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0000_0000;
      hrdata_ff <= 32'h0000_0000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else if (CE_IN) begin
      wr_pend_ff <= wr_req;
      wr_addr_ff <= wr_req ? HADDR_IN : wr_addr_ff;
      hrdata_ff <= rd_req ? rd_val : hrdata_ff;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
  end

  assign HRDATA_OUT = hrdata_ff;

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      err_mask_ff <= mefu_pkg::MEFU_REG_RST;
      irq_mask_ff <= mefu_pkg::MEFU_REG_RST;
      stat_en_ff <= '0;
      tmr_per_ff <= '0;
      stat_ff <= '0;
    end else if (CE_IN) begin
      err_mask_ff <= nxt_err_mask;
      irq_mask_ff <= nxt_irq_mask;
      stat_en_ff <= nxt_stat_en;
      tmr_per_ff <= nxt_tmr_per;
      stat_ff <= nxt_stat;
    end
  end

  // flags registered so the pins never glitch on mask writes
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_flag_ff <= 1'b0;
      fault_flag_ff <= 1'b0;
      stat_irq_ff <= 1'b0;
    end else if (CE_IN) begin
      irq_flag_ff <= irq_any;
      fault_flag_ff <= fault_any;
      stat_irq_ff <= |(nxt_stat & nxt_stat_en);
    end
  end

  assign IRQ_OUTPUT_OUT = irq_flag_ff;
  assign FAULT_OUTPUT_OUT = fault_flag_ff;
  assign STATUS_IRQ_OUT = stat_irq_ff;

  chk_irq_flag_or: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN |=> IRQ_OUTPUT_OUT == $past(|(irq_src & irq_mask_ff[25:13]))
  ) else $error("interrupt flag differs from masked event or");

  chk_fault_flag_or: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN |=> FAULT_OUTPUT_OUT == $past(|(err_src & err_mask_ff[26:16]))
  ) else $error("fault flag differs from masked event or");

  chk_src_layout: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (irq_src[7:0] == HIT_FULL_IN) && (irq_src[9:8] == IF_FULL_IN) &&
    (irq_src[10] == PLL_UNLOCK_IN) && (irq_src[11] == HIT_EMPTY_IN) && (irq_src[12] == tmr_expired)
  ) else $error("interrupt source vector out of order");

  chk_fault_no_empty: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && HIT_FULL_IN == '0 && IF_FULL_IN == '0 && !PLL_UNLOCK_IN) |=> !FAULT_OUTPUT_OUT
  ) else $error("fault flag raised by empty or timer event");

  chk_fault_all_unmask: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && err_mask_ff[26:16] == 11'h7ff && (|err_src)) |=> FAULT_OUTPUT_OUT
  ) else $error("unmasked fault condition did not raise the fault flag");

  chk_timer_irq: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && $rose(tmr_expired) && irq_mask_ff[25]) |=> IRQ_OUTPUT_OUT
  ) else $error("timer end did not raise the interrupt flag");

  chk_flags_high: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && (|(irq_src & irq_mask_ff[25:13]))) ##1 CE_IN |-> IRQ_OUTPUT_OUT ##1 IRQ_OUTPUT_OUT == $past(irq_any)
  ) else $error("interrupt flag not active high");

  chk_flag_release: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && !(|(err_src & err_mask_ff[26:16])) && !(|(irq_src & irq_mask_ff[25:13])))
      |=> !FAULT_OUTPUT_OUT && !IRQ_OUTPUT_OUT
  ) else $error("flag held after all unmasked events cleared");

  chk_sticky_hold: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && (|irq_src) && !wr_stat) |=> ((stat_ff & $past(irq_src)) == $past(irq_src))
  ) else $error("status bit lost an event");

  chk_status_clear: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && wr_stat) |=> (stat_ff & $past(wdat[IW-1:0] & ~irq_src)) == '0
  ) else $error("status bit survived a clear without an event");

  chk_status_irq: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN |=> STATUS_IRQ_OUT == |(stat_ff & stat_en_ff)
  ) else $error("status interrupt differs from enabled status");

  chk_sten_hold: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && !wr_sten) |=> $stable(stat_en_ff)
  ) else $error("status enable changed without a write");

  // bus side: zero wait states, so ready and okay never move
  chk_bus_okay: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    HREADYOUT_OUT && !HRESP_OUT
  ) else $error("bus slave not ready or not okay");

  chk_rdata_load: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && rd_req) |=> HRDATA_OUT == $past(rd_val)
  ) else $error("read data not loaded at the address edge");

  chk_rdata_hold: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    !(CE_IN && rd_req) |=> $stable(HRDATA_OUT)
  ) else $error("read data moved without a read");

  chk_wr_pend_pulse: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && !wr_req) |=> !wr_pend_ff
  ) else $error("write data phase without an address phase");

  // mask registers only move on their own write
  chk_err_mask_wr: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && wr_err) |=> err_mask_ff == $past(wdat)
  ) else $error("fault mask write lost");

  chk_irq_mask_wr: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && wr_irq) |=> irq_mask_ff == $past(wdat)
  ) else $error("interrupt mask write lost");

  chk_mask_hold: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && !wr_err && !wr_irq) |=> $stable(err_mask_ff) && $stable(irq_mask_ff)
  ) else $error("mask register changed without a write");

  chk_fault_masked: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && err_mask_ff[26:16] == 11'h000) |=> !FAULT_OUTPUT_OUT
  ) else $error("fault flag raised with every source masked");

  chk_irq_masked: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && irq_mask_ff[25:13] == 13'h0000) |=> !IRQ_OUTPUT_OUT
  ) else $error("interrupt flag raised with every source masked");

  // enable low must hold the pins, or a host sees a half update
  chk_freeze_flags: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    !CE_IN |=> $stable(IRQ_OUTPUT_OUT) && $stable(FAULT_OUTPUT_OUT) && $stable(STATUS_IRQ_OUT)
  ) else $error("flag moved while clock enable was low");

  // timer expiry is a level that only a restart removes
  chk_timer_hold: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && tmr_expired && !tmr_start) |=> tmr_expired
  ) else $error("timer expiry dropped without a restart");

  chk_timer_run: assert property (
    @(posedge CLK_IN) disable iff (!ARST_N_IN)
    (CE_IN && tmr_start && wdat[mefu_pkg::MEFU_TMR_PER_LSB +: PW] != '0) |=> tmr_running
  ) else $error("timer not running after a start");

endmodule

// ### test/mefu_host_mon.sv
// host side model that watches the two flag pins
`timescale 1ns/1ps
module mefu_host_mon (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic irq_in,
  input wire logic fault_in,
  output logic [7:0] irq_rises_out,
  output logic [7:0] fault_rises_out
);
  logic irq_ff;
  logic fault_ff;
  // flags are levels, so count rising edges only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_ff <= 1'b0;
      fault_ff <= 1'b0;
      irq_rises_out <= 8'h00;
      fault_rises_out <= 8'h00;
    end else begin
      irq_ff <= irq_in;
      fault_ff <= fault_in;
      if (irq_in && !irq_ff) begin
        irq_rises_out <= irq_rises_out + 8'h01;
      end
      if (fault_in && !fault_ff) begin
        fault_rises_out <= fault_rises_out + 8'h01;
      end
    end
  end
endmodule

// ### test/masked_event_flag_unit_tb.sv
// self-checking bench for the masked event flag unit
`timescale 1ns/1ps
module masked_event_flag_unit_tb;
  logic clk;
  logic rst_n;
  logic ce;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans;
  logic [11:0] ev;
  logic hready;
  logic hresp;
  logic irq;
  logic fault;
  logic st_irq;
  logic [7:0] irq_rises;
  logic [7:0] fault_rises;
  int fails = 0;
  int n_compared = 0;
  int n;

  mefu_top uut (.CLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(ce), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .HIT_FULL_IN(ev[7:0]), .IF_FULL_IN(ev[9:8]),
    .PLL_UNLOCK_IN(ev[10]), .HIT_EMPTY_IN(ev[11]), .IRQ_OUTPUT_OUT(irq),
    .FAULT_OUTPUT_OUT(fault), .STATUS_IRQ_OUT(st_irq));

  mefu_host_mon host (.clk_in(clk), .arst_n_in(rst_n), .irq_in(irq), .fault_in(fault),
    .irq_rises_out(irq_rises), .fault_rises_out(fault_rises));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // zero wait states today, but never assume it
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 50) begin
        cmp("hready", 32'h0000_0001, {31'h0000_0000, hready});
        end_sim();
      end
      @(posedge clk);
    end
  endtask

  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // one edge for the flag register, then realign on an edge
  task automatic chk_flags(input logic ei, input logic ef);
    @(posedge clk);
    #1;
    cmp("irq flag", {31'h0000_0000, ei}, {31'h0000_0000, irq});
    cmp("fault flag", {31'h0000_0000, ef}, {31'h0000_0000, fault});
    @(posedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    htrans = 2'b00;
    hwdata = 32'h0000_0000;
    ev = 12'h000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, mefu_pkg::MEFU_IDX_ERR_MASK, 32'h0000_0000);
    cmp("err mask reset", 32'h0000_0000, rd);
    xfer(1'b0, mefu_pkg::MEFU_IDX_IRQ_MASK, 32'h0000_0000);
    cmp("irq mask reset", 32'h0000_0000, rd);
    cmp("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    chk_flags(1'b0, 1'b0);
    for (int i = 0; i < 12; i++) begin
      xfer(1'b1, mefu_pkg::MEFU_IDX_ERR_MASK, 32'h07FF_0000);
      xfer(1'b1, mefu_pkg::MEFU_IDX_IRQ_MASK, 32'h03FF_E000 & ~(32'h0000_2000 << i));
      ev <= 12'h001 << i;
      chk_flags(1'b0, i < 11);
      xfer(1'b1, mefu_pkg::MEFU_IDX_ERR_MASK, (i < 11) ? (32'h0001_0000 << i) : 32'h0000_0000);
      xfer(1'b1, mefu_pkg::MEFU_IDX_IRQ_MASK, 32'h0000_2000 << i);
      chk_flags(1'b1, i < 11);
      ev <= 12'h000;
      chk_flags(1'b0, 1'b0);
    end
    // sticky status, its enable and write one to clear
    xfer(1'b0, mefu_pkg::MEFU_IDX_STATUS, 32'h0000_0000);
    cmp("status", 32'h0000_0FFF, rd);
    cmp("status irq masked", 32'h0000_0000, {31'h0000_0000, st_irq});
    xfer(1'b1, mefu_pkg::MEFU_IDX_STAT_EN, 32'h0000_0001);
    @(posedge clk);
    #1;
    cmp("status irq", 32'h0000_0001, {31'h0000_0000, st_irq});
    @(posedge clk);
    xfer(1'b1, mefu_pkg::MEFU_IDX_STATUS, 32'h0000_0FFF);
    xfer(1'b0, mefu_pkg::MEFU_IDX_STATUS, 32'h0000_0000);
    cmp("status cleared", 32'h0000_0000, rd);
    cmp("status irq cleared", 32'h0000_0000, {31'h0000_0000, st_irq});
    // timer end on the interrupt flag, period of two ticks
    xfer(1'b1, mefu_pkg::MEFU_IDX_IRQ_MASK, 32'h0200_0000);
    xfer(1'b1, mefu_pkg::MEFU_IDX_TIMER, 32'h0001_0002);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp("timer delay", 32'h0000_0007, n);
    @(posedge clk);
    xfer(1'b0, mefu_pkg::MEFU_IDX_TIMER, 32'h0000_0000);
    cmp("timer state", 32'h0004_0000, rd & 32'h0006_0000);
    xfer(1'b0, 6'h01, 32'h0000_0000);
    cmp("unmapped read", 32'h0000_0000, rd);
    xfer(1'b1, mefu_pkg::MEFU_IDX_ERR_MASK, 32'hFFFF_FFFF);
    xfer(1'b0, mefu_pkg::MEFU_IDX_ERR_MASK, 32'h0000_0000);
    cmp("err mask width", 32'h0FFF_FFFF, rd);
    // enable low holds the flags, they catch up once it returns
    ce <= 1'b0;
    ev <= 12'h001;
    chk_flags(1'b1, 1'b0);
    ce <= 1'b1;
    chk_flags(1'b1, 1'b1);
    ev <= 12'h000;
    chk_flags(1'b1, 1'b0);
    cmp("irq rises", 32'h0000_000D, {24'h00_0000, irq_rises});
    cmp("fault rises", 32'h0000_000C, {24'h00_0000, fault_rises});
    end_sim();
  end
endmodule
